/* inc/scg_pkg.sv */
// Package for the serial transfer clock generator.
// Assumes a 32-bit APB slave with byte addresses in paddr[7:0].
package scg_pkg;

	localparam logic [7:0] ADDR_BAUD_CTRL = 8'h00;
	localparam logic [7:0] ADDR_BAUD_FRAC = 8'h04;
	localparam logic [7:0] ADDR_MODE      = 8'h08;
	localparam logic [7:0] ADDR_CTRL      = 8'h0c;
	localparam logic [7:0] ADDR_STATUS    = 8'h10;

	// baud_control_register fields
	localparam int SEL_LSB  = 0;
	localparam int N_LSB    = 4;
	localparam int FRAC_BIT = 8;
	// baud_fraction_register field
	localparam int K_LSB = 0;
	// serial_mode_register_zero fields
	localparam int MODE_BIT = 0;
	localparam int SRC_LSB  = 2;
	// serial_control_register fields
	localparam int EDGE_BIT = 0;
	localparam int DIR_BIT  = 1;

	// Prescaler tap masks: divide by 2, 8, 32, 128
	localparam logic [6:0] TAP_DIV2   = 7'h01;
	localparam logic [6:0] TAP_DIV8   = 7'h07;
	localparam logic [6:0] TAP_DIV32  = 7'h1f;
	localparam logic [6:0] TAP_DIV128 = 7'h7f;

	// Asynchronous clock source codes
	localparam logic [1:0] SRC_TIMER = 2'h0;
	localparam logic [1:0] SRC_BAUD  = 2'h1;
	localparam logic [1:0] SRC_FSYS  = 2'h2;
	localparam logic [1:0] SRC_SCLK  = 2'h3;

	localparam logic [4:0] FRAC_ONE    = 5'h10;
	localparam logic [4:0] N_ZERO_AS   = 5'h10;
	localparam logic [3:0] BIT_DIV_TOP = 4'hf;

	// Reset values
	localparam logic [1:0] RST_SEL  = 2'h0;
	localparam logic [3:0] RST_N    = 4'h0;
	localparam logic [3:0] RST_K    = 4'h0;
	localparam logic [1:0] RST_SRC  = 2'h1;

	typedef struct packed {
		logic       frac_en;
		logic [3:0] n;
		logic [1:0] in_sel;
		logic [3:0] k;
		logic       async_mode;
		logic [1:0] async_src;
		logic       sclk_in_mode;
		logic       edge_fall;
	} scg_cfg_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} scg_apb_s;

	typedef enum logic [0:0] {
		SCG_IDLE,
		SCG_ANSWER
	} scg_apb_e;

endpackage

/* rtl/scg_serial_clock_gen.sv */
// Transfer clock generator: prescaler taps, baud divider, clock select.
// Assumes a prescaler tick pulse and a timer tick pulse synchronous to pclk;
// the shift clock input is synchronised here; APB master on pclk.
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Baud input is prescaler tick divided by 2, 8, 32 or 128.
// - Synchronous mode divides by N only; asynchronous may pick fractional.
// - Mode field picks source: control register or asynchronous source field.
// - Driven shift clock is baud output halved, rising edge only.
// - External shift clock shifts on the rising or falling edge selected.
// - Asynchronous transfer clock is divided by sixteen to time bits.
module scg_serial_clock_gen
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        prescaler_tick,
	input  wire logic        timer_tick,
	input  wire logic        sclk_in,
	output logic             sclk_out,
	output logic             sclk_oe,
	output logic             transfer_tick,
	output logic             bit_tick
);

	scg_pkg::scg_cfg_s cfg;
	scg_pkg::scg_cfg_s next_cfg;
	scg_pkg::scg_apb_s apb;
	scg_pkg::scg_apb_s next_apb;
	scg_pkg::scg_apb_e state;
	scg_pkg::scg_apb_e next_state;

	logic [6:0] presc_cnt;
	logic [6:0] next_presc_cnt;
	logic [4:0] bg_cnt;
	logic [4:0] next_bg_cnt;
	logic [3:0] frac_acc;
	logic [3:0] next_frac_acc;
	logic       frac_extra;
	logic       next_frac_extra;
	logic [3:0] bit_cnt;
	logic [3:0] next_bit_cnt;
	logic       sclk_s1;
	logic       sclk_s2;
	logic       sclk_s3;
	logic       next_sclk_out;
	logic       next_sclk_oe;
	logic       next_transfer_tick;
	logic       next_bit_tick;

	logic [6:0] tap_mask;
	logic       tap_tick;
	logic [4:0] n_val;
	logic [4:0] period;
	logic [4:0] frac_sum;
	logic       bg_tick;
	logic       sclk_rise;
	logic       sclk_fall;
	logic       src_tick;
	logic       shift_tick;
	logic       acc_phase;
	logic [31:0] rd_word;

	// APB slave: answer in the second access cycle
	always_comb
	begin
		next_cfg   = cfg;
		next_apb   = apb;
		next_state = scg_pkg::SCG_IDLE;
		acc_phase  = psel && penable && (state == scg_pkg::SCG_IDLE);
		rd_word    = 32'h0;
		next_apb.pready  = 1'b0;
		next_apb.pslverr = 1'b0;
		case (paddr)
			scg_pkg::ADDR_BAUD_CTRL:
			begin
				rd_word[scg_pkg::SEL_LSB +: 2] = cfg.in_sel;
				rd_word[scg_pkg::N_LSB +: 4]   = cfg.n;
				rd_word[scg_pkg::FRAC_BIT]     = cfg.frac_en;
			end
			scg_pkg::ADDR_BAUD_FRAC:
				rd_word[scg_pkg::K_LSB +: 4] = cfg.k;
			scg_pkg::ADDR_MODE:
			begin
				rd_word[scg_pkg::MODE_BIT]    = cfg.async_mode;
				rd_word[scg_pkg::SRC_LSB +: 2] = cfg.async_src;
			end
			scg_pkg::ADDR_CTRL:
			begin
				rd_word[scg_pkg::EDGE_BIT] = cfg.edge_fall;
				rd_word[scg_pkg::DIR_BIT]  = cfg.sclk_in_mode;
			end
			scg_pkg::ADDR_STATUS:
				rd_word = {24'h0, bit_cnt, frac_acc[0],
					sclk_s2, sclk_oe, sclk_out};
			default:
				rd_word = 32'h0;
		endcase
		if (acc_phase)
		begin
			next_state        = scg_pkg::SCG_ANSWER;
			next_apb.pready   = 1'b1;
			next_apb.prdata   = pwrite ? 32'h0 : rd_word;
			case (paddr)
				scg_pkg::ADDR_BAUD_CTRL:
				begin
					if (pwrite)
					begin
						next_cfg.in_sel  = pwdata[scg_pkg::SEL_LSB +: 2];
						next_cfg.n       = pwdata[scg_pkg::N_LSB +: 4];
						next_cfg.frac_en = pwdata[scg_pkg::FRAC_BIT];
					end
				end
				scg_pkg::ADDR_BAUD_FRAC:
				begin
					if (pwrite)
						next_cfg.k = pwdata[scg_pkg::K_LSB +: 4];
				end
				scg_pkg::ADDR_MODE:
				begin
					if (pwrite)
					begin
						next_cfg.async_mode = pwdata[scg_pkg::MODE_BIT];
						next_cfg.async_src  = pwdata[scg_pkg::SRC_LSB +: 2];
					end
				end
				scg_pkg::ADDR_CTRL:
				begin
					if (pwrite)
					begin
						next_cfg.edge_fall    = pwdata[scg_pkg::EDGE_BIT];
						next_cfg.sclk_in_mode = pwdata[scg_pkg::DIR_BIT];
					end
				end
				scg_pkg::ADDR_STATUS:
					next_apb.pslverr = pwrite;
				default:
					next_apb.pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= scg_pkg::SCG_IDLE;
			apb   <= '0;
			cfg   <= '{frac_en: 1'b0, n: scg_pkg::RST_N,
				in_sel: scg_pkg::RST_SEL, k: scg_pkg::RST_K,
				async_mode: 1'b0, async_src: scg_pkg::RST_SRC,
				sclk_in_mode: 1'b0, edge_fall: 1'b0};
		end
		else
		begin
			state <= next_state;
			apb   <= next_apb;
			cfg   <= next_cfg;
		end
	end

	assign prdata  = apb.prdata;
	assign pready  = apb.pready;
	assign pslverr = apb.pslverr;

	// Prescaler taps and baud divider
	always_comb
	begin
		case (cfg.in_sel)
			2'h0:    tap_mask = scg_pkg::TAP_DIV2;
			2'h1:    tap_mask = scg_pkg::TAP_DIV8;
			2'h2:    tap_mask = scg_pkg::TAP_DIV32;
			default: tap_mask = scg_pkg::TAP_DIV128;
		endcase
		tap_tick = prescaler_tick && ((presc_cnt & tap_mask) == tap_mask);
		next_presc_cnt = prescaler_tick ? 7'(presc_cnt + 7'h1) : presc_cnt;
		// Field value zero stands for sixteen
		n_val  = (cfg.n == 4'h0) ? scg_pkg::N_ZERO_AS : {1'b0, cfg.n};
		period = 5'(n_val + {4'h0, frac_extra});
		frac_sum = 5'({1'b0, frac_acc}
			+ 5'(scg_pkg::FRAC_ONE - {1'b0, cfg.k}));
		bg_tick         = 1'b0;
		next_bg_cnt     = bg_cnt;
		next_frac_acc   = frac_acc;
		next_frac_extra = frac_extra;
		if (tap_tick)
		begin
			if (5'(bg_cnt + 5'h1) >= period)
			begin
				bg_tick     = 1'b1;
				next_bg_cnt = 5'h0;
				// Accumulator carry stretches one period in sixteen-K spots
				if (cfg.async_mode && cfg.frac_en)
				begin
					next_frac_acc   = frac_sum[3:0];
					next_frac_extra = frac_sum[4];
				end
				else
				begin
					next_frac_acc   = 4'h0;
					next_frac_extra = 1'b0;
				end
			end
			else
				next_bg_cnt = 5'(bg_cnt + 5'h1);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			presc_cnt  <= 7'h0;
			bg_cnt     <= 5'h0;
			frac_acc   <= 4'h0;
			frac_extra <= 1'b0;
		end
		else
		begin
			presc_cnt  <= next_presc_cnt;
			bg_cnt     <= next_bg_cnt;
			frac_acc   <= next_frac_acc;
			frac_extra <= next_frac_extra;
		end
	end

	// Shift clock input synchroniser; only s2 and s3 feed logic
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_s3 <= 1'b0;
		end
		else
		begin
			sclk_s1 <= sclk_in;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
		end
	end

	assign sclk_rise = sclk_s2 && !sclk_s3;
	assign sclk_fall = !sclk_s2 && sclk_s3;

	// Clock selection, shift clock and bit timing
	always_comb
	begin
		next_sclk_out = sclk_out;
		next_sclk_oe  = 1'b0;
		next_bit_cnt  = bit_cnt;
		next_bit_tick = 1'b0;
		src_tick      = 1'b0;
		shift_tick    = 1'b0;
		if (cfg.async_mode)
		begin
			next_sclk_out = 1'b0;
			case (cfg.async_src)
				scg_pkg::SRC_TIMER: src_tick = timer_tick;
				scg_pkg::SRC_BAUD:  src_tick = bg_tick;
				scg_pkg::SRC_FSYS:  src_tick = 1'b1;
				scg_pkg::SRC_SCLK:  src_tick = sclk_rise;
				default:            src_tick = 1'b0;
			endcase
			if (src_tick)
			begin
				next_bit_cnt  = 4'(bit_cnt + 4'h1);
				next_bit_tick = (bit_cnt == scg_pkg::BIT_DIV_TOP);
			end
		end
		else if (cfg.sclk_in_mode)
		begin
			// Partner must respect the minimum period to be caught here
			next_sclk_out = 1'b0;
			src_tick   = cfg.edge_fall ? sclk_fall : sclk_rise;
			shift_tick = src_tick;
			next_bit_cnt  = 4'h0;
			next_bit_tick = shift_tick;
		end
		else
		begin
			next_sclk_oe = 1'b1;
			// Toggle per baud tick halves it; shifting is on the rise
			if (bg_tick)
			begin
				next_sclk_out = !sclk_out;
				shift_tick    = !sclk_out;
			end
			src_tick      = shift_tick;
			next_bit_cnt  = 4'h0;
			next_bit_tick = shift_tick;
		end
		next_transfer_tick = src_tick;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sclk_out      <= 1'b0;
			sclk_oe       <= 1'b0;
			bit_cnt       <= 4'h0;
			bit_tick      <= 1'b0;
			transfer_tick <= 1'b0;
		end
		else
		begin
			sclk_out      <= next_sclk_out;
			sclk_oe       <= next_sclk_oe;
			bit_cnt       <= next_bit_cnt;
			bit_tick      <= next_bit_tick;
			transfer_tick <= next_transfer_tick;
		end
	end

endmodule // scg_serial_clock_gen

`default_nettype wire

/* sim/scg_checker_sva.sv */
// Checker for the serial transfer clock generator, bound to its top module.
// Assumes APB config writes land at the first access edge, as handed over.
`timescale 1ns/100ps
`default_nettype none
module scg_sva_chk
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        sclk_in,
	input wire logic        sclk_out,
	input wire logic        sclk_oe,
	input wire logic        transfer_tick,
	input wire logic        bit_tick
);
	logic async_m;

	// Shadow of the mode bit, taken from the bus
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			async_m <= 1'b0;
		else if (psel && penable && !pready && pwrite && paddr == scg_pkg::ADDR_MODE)
			async_m <= pwdata[scg_pkg::MODE_BIT];

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
	ready_answer_a: assert property (psel && penable && !pready |=> pready) else $error("no answer");
	err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
	out_rise_a: assert property (sclk_oe && bit_tick |-> transfer_tick && $rose(sclk_out)) else $error("bad shift");
	out_idle_a: assert property (!sclk_oe |-> !sclk_out) else $error("sclk_out while not driving");
	async_oe_a: assert property (async_m && $past(async_m) |-> !sclk_oe) else $error("drive in async");
	async_bit_a: assert property (async_m && bit_tick |=> !bit_tick [*8]) else $error("bit tick early");
	in_sync_a: assert property (!async_m && !sclk_oe && !$past(sclk_oe) && bit_tick |->
		$past(sclk_in, 3) != $past(sclk_in, 4) || $past(sclk_in, 4) != $past(sclk_in, 5)
		|| $past(sclk_in, 5) != $past(sclk_in, 6)) else $error("shift without input edge");
endmodule // scg_sva_chk

bind scg_serial_clock_gen scg_sva_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .sclk_in(sclk_in),
	.sclk_out(sclk_out), .sclk_oe(sclk_oe), .transfer_tick(transfer_tick), .bit_tick(bit_tick));
`default_nettype wire

/* sim/scg_peer.sv */
// Far-side peer that supplies the external shift clock.
// Assumes pclk from the bench; the clock stands still while run is low.
`timescale 1ns/100ps
`default_nettype none
module scg_peer
#(
	parameter int HI = 4,
	parameter int LO = 6
)
(
	input  wire logic pclk,
	input  wire logic run,
	output var logic  sclk_in
);
	int c = 0;

	initial sclk_in = 1'b0;
	// Period of ten keeps above the eight-cycle minimum in both modes that take this clock
	always @(posedge pclk)
		if (run)
		begin
			c <= (c == HI + LO - 1) ? 0 : c + 1;
			sclk_in <= c < HI;
		end
endmodule // scg_peer
`default_nettype wire

/* sim/test_serial_clock_generation.sv */
// Bench for the serial transfer clock generator: bus, taps, modes, edges.
// Assumes the peer model and the bound checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module test_serial_clock_generation;
	logic        pclk, presetn, psel, penable, pwrite, prescaler_tick, timer_tick, run;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, sclk_in, sclk_out, sclk_oe, transfer_tick, bit_tick;
	logic [1:0]  tcnt;
	logic [32:0] q[$];
	int          errors, n_compared, seed, i, c, n, lat[2];
	int          dv[4] = '{2, 8, 32, 128};
	int          asy[5][4] = '{'{0, 'h20, 0, 48}, '{1, 'h20, 0, 128}, '{1, 'h120, 8, 160}, '{2, 'h20, 0, 16},
		'{3, 'h20, 0, 160}};

	scg_serial_clock_gen dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.prescaler_tick(prescaler_tick), .timer_tick(timer_tick), .sclk_in(sclk_in), .sclk_out(sclk_out),
		.sclk_oe(sclk_oe), .transfer_tick(transfer_tick), .bit_tick(bit_tick));
	scg_peer peer (.pclk(pclk), .run(run), .sclk_in(sclk_in));

	always #12.5 pclk = ~pclk;

	// Tick at half the system rate, timer every third cycle
	always @(posedge pclk)
	begin
		prescaler_tick <= ~prescaler_tick;
		tcnt <= (tcnt == 2'h2) ? 2'h0 : tcnt + 2'h1;
		timer_tick <= tcnt == 2'h0;
	end

	always @(posedge pclk)
		if (pready === 1'b1)
			check({pslverr, prdata}, q.pop_front());

	task check(input logic [32:0] seen, input logic [32:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
		int k;
		k = 0;
		q.push_back(e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++k < 20);
		if (k >= 20)
			errors++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rst();
		presetn <= 1'b0;
		run <= 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	// Cycles between the second and third bit ticks
	task span(output int s);
		s = 0;
		repeat (2) do @(posedge pclk); while (bit_tick !== 1'b1);
		do
		begin
			@(posedge pclk);
			s++;
		end
		while (bit_tick !== 1'b1 && s < 9000);
	endtask

	task summarize();
		// An answer that never came leaves its note behind
		if (q.size() != 0)
			errors++;
		if (errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		#(25 * 60000);
		errors++;
		summarize();
	end

	initial
	begin
		{pclk, presetn, psel, penable, pwrite, prescaler_tick, timer_tick, run, tcnt} = '0;
		paddr = 8'h00;
		pwdata = 32'h0;
		seed = 11268;
		rst();
		apb(0, scg_pkg::ADDR_MODE, 32'h0, {29'h0, scg_pkg::RST_SRC, 2'h0});
		apb(0, scg_pkg::ADDR_CTRL, 32'h0, 33'h0);
		apb(1, 8'h14, 32'hffffffff, {1'b1, 32'h0});
		apb(1, scg_pkg::ADDR_STATUS, 32'hffffffff, {1'b1, 32'h0});
		apb(1, scg_pkg::ADDR_BAUD_CTRL, 32'hffffffff, 33'h0);
		apb(0, scg_pkg::ADDR_BAUD_CTRL, 32'h0, 33'h1f3);
		for (i = 0; i < 5; i++)
		begin
			rst();
			n = (i == 4) ? 16 : 2 + {$random(seed)} % 14;
			// Fraction enable in synchronous mode must not stretch the period
			apb(1, scg_pkg::ADDR_BAUD_CTRL, {23'h0, i == 4, n[3:0], 2'h0, i[1:0]}, 33'h0);
			span(c);
			check(33'(c), 33'(4 * n * dv[i % 4]));
		end
		for (i = 0; i < 5; i++)
		begin
			rst();
			apb(1, scg_pkg::ADDR_BAUD_CTRL, 32'(asy[i][1]), 33'h0);
			apb(1, scg_pkg::ADDR_BAUD_FRAC, 32'(asy[i][2]), 33'h0);
			apb(1, scg_pkg::ADDR_MODE, 32'(asy[i][0] * 4 + 1), 33'h0);
			// Peer period of ten feeds the shift clock source case
			run <= 1'b1;
			span(c);
			check(33'(c), 33'(asy[i][3]));
		end
		for (i = 0; i < 2; i++)
		begin
			rst();
			apb(1, scg_pkg::ADDR_CTRL, {30'h0, 1'b1, i[0]}, 33'h0);
			run <= 1'b1;
			repeat (2) @(posedge sclk_in);
			c = 0;
			do
			begin
				@(posedge pclk);
				c++;
			end
			while (bit_tick !== 1'b1 && c < 40);
			lat[i] = c;
		end
		check(33'(lat[1] - lat[0]), 33'h4);
		summarize();
	end
endmodule // test_serial_clock_generation
`default_nettype wire
